// ==== design/serial_tx.sv ====
// Asynchronous serial transmitter with break detection on receive, AHB-Lite slave.
// Assumes RX_PIN_IN is asynchronous; every other input is on SYS_CLK.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module serial_tx
    import serial_tx_pkg::*;
#(
    parameter int BAUD_W = 8
) (
    input  wire logic        SYS_CLK,
    input  wire logic        SRST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic             TX_PIN_OUT,
    output logic             TX_PIN_OE_N,
    input  wire logic        RX_PIN_IN,
    output logic             TX_IRQ,
    output logic             RX_IRQ
);
    if (BAUD_W < 5) begin : g_bad_width
        $error("BAUD_W must hold the five rate bits");
    end

    typedef enum logic [2:0] {TXS_IDLE, TXS_PREAMBLE, TXS_DATA, TXS_BREAK, TXS_MARK} txs_t;
    typedef enum logic {RXS_IDLE, RXS_RUN} rxs_t;

    typedef struct packed {
        logic [7:0]        addr_q;
        logic              wr_q;
        logic [31:0]       rdata;
        logic              ready;
        logic              resp;
        logic [7:0]        ctl1;
        logic [7:0]        ctl2;
        logic [7:0]        ctl3;
        logic [7:0]        rate;
        logic [7:0]        tbuf;
        logic              buf_full;
        logic              empty_f;
        logic              done_f;
        logic              tx_armed;
        logic              te_q;
        logic              idle_pend;
        txs_t              txs;
        logic [10:0]       tsh;
        logic [3:0]        tcnt;
        logic [3:0]        tsub;
        logic              ld;
        logic [BAUD_W-1:0] baud_cnt;
        logic              tick;
        logic              pin;
        logic              oe_n;
        logic              rx_s1;
        logic              rx_s2;
        logic              rx_s3;
        rxs_t              rxs;
        logic [3:0]        rsub;
        logic [3:0]        rbit;
        logic [9:0]        rsh;
        logic [7:0]        rbuf;
        logic              rx_full;
        logic              fe;
        logic              ovr;
        logic              brk;
        logic              rx_armed;
        logic              tx_irq;
        logic              rx_irq;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    logic       char9;
    logic [3:0] flen;
    logic       bit_tick;
    logic       accept;
    logic [9:0] rx_sh;
    logic [7:0] rx_data;
    logic       rx_brk;

    assign char9    = s_r.ctl1[C1_CHAR9];
    assign flen     = char9 ? FRAME_LEN9 : FRAME_LEN8;
    assign bit_tick = s_r.tick && (s_r.tsub == TICK_LAST);
    assign accept   = HSEL && HREADY && ((HTRANS & HTRANS_NONSEQ_BIT) != 2'h0);
    assign rx_sh    = {s_r.rx_s2, s_r.rsh[9:1]};
    assign rx_data  = char9 ? rx_sh[7:0] : rx_sh[8:1];
    assign rx_brk   = char9 ? (rx_sh == 10'h000) : (rx_sh[9:1] == 9'h000);

    always_comb begin
        s_nxt       = s_r;
        s_nxt.ld    = 1'b0;
        s_nxt.ready = 1'b1;
        s_nxt.resp  = 1'b0;
        s_nxt.rx_s1 = RX_PIN_IN;
        s_nxt.rx_s2 = s_r.rx_s1;
        s_nxt.rx_s3 = s_r.rx_s2;

        // Address phase: latch write target, answer reads at once
        s_nxt.wr_q   = accept && HWRITE;
        s_nxt.addr_q = HADDR[7:0];
        if (accept && !HWRITE) begin
            s_nxt.rdata = 32'h0;
            unique case (HADDR[7:0])
                A_CONTROL_ONE:   s_nxt.rdata[7:0] = s_r.ctl1;
                A_CONTROL_TWO:   s_nxt.rdata[7:0] = s_r.ctl2;
                A_CONTROL_THREE: s_nxt.rdata[7:0] = s_r.ctl3;
                A_STATUS_ONE: begin
                    s_nxt.rdata[S1_EMPTY]   = s_r.empty_f;
                    s_nxt.rdata[S1_DONE]    = s_r.done_f;
                    s_nxt.rdata[S1_RX_FULL] = s_r.rx_full;
                    s_nxt.rdata[S1_OVERRUN] = s_r.ovr;
                    s_nxt.rdata[S1_FRAMING] = s_r.fe;
                    s_nxt.tx_armed = s_r.tx_armed || s_r.empty_f;
                    s_nxt.rx_armed = 1'b1;
                end
                A_STATUS_TWO: begin
                    s_nxt.rdata[S2_BREAK]     = s_r.brk;
                    s_nxt.rdata[S2_RX_ACTIVE] = (s_r.rxs == RXS_RUN);
                end
                A_TX_RX_BUFFER: begin
                    s_nxt.rdata[7:0] = s_r.rbuf;
                    // Receive flags clear only after a status_one read
                    if (s_r.rx_armed) begin
                        s_nxt.rx_full  = 1'b0;
                        s_nxt.fe       = 1'b0;
                        s_nxt.ovr      = 1'b0;
                        s_nxt.brk      = 1'b0;
                        s_nxt.rx_armed = 1'b0;
                    end
                end
                A_BIT_RATE:      s_nxt.rdata[7:0] = s_r.rate;
                default:         s_nxt.rdata = 32'h0;
            endcase
        end

        // Data phase of a write
        if (s_r.wr_q) begin
            unique case (s_r.addr_q)
                A_CONTROL_ONE: s_nxt.ctl1 = HWDATA[7:0];
                A_CONTROL_TWO: s_nxt.ctl2 = HWDATA[7:0];
                A_CONTROL_THREE: begin
                    s_nxt.ctl3 = (HWDATA[7:0] & C3_WMASK) | (s_r.ctl3 & ~C3_WMASK);
                end
                A_TX_RX_BUFFER: begin
                    s_nxt.tbuf     = HWDATA[7:0];
                    s_nxt.buf_full = 1'b1;
                    if (s_r.tx_armed) begin
                        s_nxt.empty_f = 1'b0;
                    end
                    s_nxt.tx_armed = 1'b0;
                end
                A_BIT_RATE:    s_nxt.rate = HWDATA[7:0] & BR_WMASK;
                default: ;
            endcase
        end

        // Sixteen ticks per bit from the rate divider
        s_nxt.tick = 1'b0;
        if (s_r.baud_cnt == '0) begin
            s_nxt.baud_cnt = BAUD_W'({s_r.rate[5:4], s_r.rate[2:0]});
            s_nxt.tick     = 1'b1;
        end else begin
            s_nxt.baud_cnt = s_r.baud_cnt - 1'b1;
        end
        if (s_r.tick) begin
            s_nxt.tsub = s_r.tsub + 4'h1;
        end

        // Transmitter
        s_nxt.te_q = s_r.ctl2[C2_TX_ENABLE];
        if (s_r.ctl2[C2_TX_ENABLE] && !s_r.te_q) begin
            s_nxt.idle_pend = 1'b1;
        end
        if (bit_tick) begin
            if (s_r.tcnt > 4'h1) begin
                s_nxt.tsh  = {1'b1, s_r.tsh[10:1]};
                s_nxt.tcnt = s_r.tcnt - 4'h1;
            end else if (s_r.ctl2[C2_SEND_BREAK]) begin
                s_nxt.txs  = TXS_BREAK;
                s_nxt.tsh  = 11'h000;
                s_nxt.tcnt = flen;
                s_nxt.ld   = 1'b1;
            end else if (s_r.txs == TXS_BREAK) begin
                s_nxt.txs  = TXS_MARK;
                s_nxt.tsh  = 11'h7ff;
                s_nxt.tcnt = 4'h1;
                s_nxt.ld   = 1'b1;
            end else if (s_nxt.idle_pend) begin
                s_nxt.txs       = TXS_PREAMBLE;
                s_nxt.tsh       = 11'h7ff;
                s_nxt.tcnt      = flen;
                s_nxt.idle_pend = 1'b0;
                s_nxt.ld        = 1'b1;
            end else if (s_r.ctl2[C2_TX_ENABLE] && s_r.buf_full) begin
                s_nxt.txs = TXS_DATA;
                s_nxt.tsh = char9 ? {1'b1, s_r.ctl3[C3_TX_NINTH], s_r.tbuf, 1'b0}
                                  : {2'b11, s_r.tbuf, 1'b0};
                s_nxt.tcnt     = flen;
                s_nxt.ld       = 1'b1;
                s_nxt.buf_full = s_r.wr_q && (s_r.addr_q == A_TX_RX_BUFFER);
                s_nxt.empty_f  = 1'b1;
            end else begin
                s_nxt.txs  = TXS_IDLE;
                s_nxt.tsh  = 11'h7ff;
                s_nxt.tcnt = 4'h0;
            end
        end

        // Receiver with break detection
        if (s_r.tick && s_r.ctl2[C2_RX_ENABLE]) begin
            unique case (s_r.rxs)
                RXS_IDLE: begin
                    // Start needs a falling edge; a line held low after a break is no frame
                    if (!s_r.rx_s2 && s_r.rx_s3) begin
                        s_nxt.rxs  = RXS_RUN;
                        s_nxt.rsub = 4'h1;
                        s_nxt.rbit = 4'h0;
                    end
                end
                RXS_RUN: begin
                    s_nxt.rsub = s_r.rsub + 4'h1;
                    if (s_r.rsub == RX_SAMPLE) begin
                        if (s_r.rbit == 4'h0) begin
                            // A high start sample was only a glitch
                            if (s_r.rx_s2) begin
                                s_nxt.rxs = RXS_IDLE;
                            end else begin
                                s_nxt.rbit = 4'h1;
                            end
                        end else begin
                            s_nxt.rsh  = rx_sh;
                            s_nxt.rbit = s_r.rbit + 4'h1;
                            if (s_r.rbit == flen - 4'h1) begin
                                s_nxt.rxs     = RXS_IDLE;
                                s_nxt.ovr     = s_nxt.ovr || s_r.rx_full;
                                s_nxt.rx_full = 1'b1;
                                s_nxt.fe      = s_nxt.fe || !s_r.rx_s2;
                                s_nxt.brk     = s_nxt.brk || rx_brk;
                                s_nxt.rbuf    = rx_brk ? 8'h00 : rx_data;
                                s_nxt.ctl3[C3_RX_NINTH] = rx_brk ? 1'b0 : rx_sh[8];
                            end
                        end
                    end
                end
            endcase
        end

        // Disabling the module stops both halves and frees the transmit pin
        if (!s_r.ctl1[C1_MODULE_ENABLE]) begin
            s_nxt.txs       = TXS_IDLE;
            s_nxt.tsh       = 11'h7ff;
            s_nxt.tcnt      = 4'h0;
            s_nxt.idle_pend = 1'b0;
            s_nxt.rxs       = RXS_IDLE;
        end
        s_nxt.oe_n   = !s_nxt.ctl1[C1_MODULE_ENABLE];
        s_nxt.pin    = s_nxt.tsh[0] ^ s_nxt.ctl1[C1_TX_INVERT];
        s_nxt.done_f = (s_nxt.txs == TXS_IDLE) && !s_nxt.buf_full
                       && !s_nxt.idle_pend && !s_nxt.ctl2[C2_SEND_BREAK];
        s_nxt.tx_irq = (s_nxt.empty_f && s_nxt.ctl2[C2_EMPTY_IE])
                       || (s_nxt.done_f && s_nxt.ctl2[C2_DONE_IE]);
        s_nxt.rx_irq = (s_nxt.rx_full && s_nxt.ctl2[C2_RX_IE])
                       || (s_nxt.ovr && s_nxt.ctl3[C3_OVERRUN_IE])
                       || (s_nxt.fe && s_nxt.ctl3[C3_FRAMING_IE]);
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            s_r         <= '0;
            s_r.ready   <= 1'b1;
            s_r.empty_f <= 1'b1;
            s_r.done_f  <= 1'b1;
            s_r.tsh     <= 11'h7ff;
            s_r.pin     <= 1'b1;
            s_r.oe_n    <= 1'b1;
            s_r.rx_s1   <= 1'b1;
            s_r.rx_s2   <= 1'b1;
            s_r.rx_s3   <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign HRDATA      = s_r.rdata;
    assign HREADYOUT   = s_r.ready;
    assign HRESP       = s_r.resp;
    assign TX_PIN_OUT  = s_r.pin;
    assign TX_PIN_OE_N = s_r.oe_n;
    assign TX_IRQ      = s_r.tx_irq;
    assign RX_IRQ      = s_r.rx_irq;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);

    sequence s_break_end;
        (s_r.txs == TXS_BREAK) ##1 (s_r.txs != TXS_BREAK);
    endsequence

    property p_preamble_len;
        s_r.ld && (s_r.txs == TXS_PREAMBLE) |-> (s_r.tsh == 11'h7ff)
            && (s_r.tcnt == (s_r.ctl1[C1_CHAR9] ? 4'hb : 4'ha));
    endproperty
    a_preamble_len: assert property (p_preamble_len) else $error("preamble length");

    property p_data_frame;
        s_r.ld && (s_r.txs == TXS_DATA) |-> !s_r.tsh[0] && s_r.tsh[s_r.tcnt - 4'h1]
            && s_r.empty_f && $past(s_r.ctl2[C2_TX_ENABLE]);
    endproperty
    a_data_frame: assert property (p_data_frame) else $error("data frame");

    property p_break_frame;
        s_r.ld && (s_r.txs == TXS_BREAK) |-> (s_r.tsh == 11'h000) && (s_r.tcnt == flen);
    endproperty
    a_break_frame: assert property (p_break_frame) else $error("break frame");

    property p_break_tail;
        s_break_end |-> (s_r.txs == TXS_MARK)
            || !$past(s_r.ctl1[C1_MODULE_ENABLE]);
    endproperty
    a_break_tail: assert property (p_break_tail) else $error("no mark after break");

    property p_idle_level;
        (s_r.txs == TXS_IDLE) |=> (TX_PIN_OUT == !s_r.ctl1[C1_TX_INVERT])
            || $changed(s_r.txs);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("pin not idle");

    property p_release;
        !s_r.ctl1[C1_MODULE_ENABLE] |-> TX_PIN_OE_N ##1 (s_r.txs == TXS_IDLE);
    endproperty
    a_release: assert property (p_release) else $error("pin not released");

    property p_empty_clear;
        $fell(s_r.empty_f) |-> $past(s_r.wr_q) && ($past(s_r.addr_q) == A_TX_RX_BUFFER)
            && $past(s_r.tx_armed);
    endproperty
    a_empty_clear: assert property (p_empty_clear) else $error("empty cleared wrongly");

    property p_rx_break;
        $rose(s_r.brk) |-> s_r.fe && s_r.rx_full && (s_r.rbuf == 8'h00)
            && !s_r.ctl3[C3_RX_NINTH];
    endproperty
    a_rx_break: assert property (p_rx_break) else $error("break effects");

    property p_done;
        s_r.done_f |-> (s_r.txs == TXS_IDLE) && !s_r.buf_full && !s_r.idle_pend;
    endproperty
    a_done: assert property (p_done) else $error("done flag wrong");

    property p_irq_hold;
        s_r.empty_f && s_r.ctl2[C2_EMPTY_IE] |-> TX_IRQ;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");

    property p_queue_idle;
        s_r.ctl2[C2_TX_ENABLE] && !s_r.te_q && (s_r.txs != TXS_IDLE)
            && s_r.ctl1[C1_MODULE_ENABLE] |=> s_r.idle_pend || (s_r.txs == TXS_PREAMBLE);
    endproperty
    a_queue_idle: assert property (p_queue_idle) else $error("idle not queued");
endmodule // serial_tx

// ==== design/serial_tx_pkg.sv ====
// Constants shared by the serial transmitter and its register file.
// Assumes a 32-bit AHB-Lite bus with one 8-bit register per aligned word.
package serial_tx_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL_ONE   = 8'h13;
    localparam logic [7:0] IDX_CONTROL_TWO   = 8'h14;
    localparam logic [7:0] IDX_CONTROL_THREE = 8'h15;
    localparam logic [7:0] IDX_STATUS_ONE    = 8'h16;
    localparam logic [7:0] IDX_STATUS_TWO    = 8'h17;
    localparam logic [7:0] IDX_TX_RX_BUFFER  = 8'h18;
    localparam logic [7:0] IDX_BIT_RATE      = 8'h19;
    localparam logic [7:0] A_CONTROL_ONE     = 8'(IDX_CONTROL_ONE * 4);
    localparam logic [7:0] A_CONTROL_TWO     = 8'(IDX_CONTROL_TWO * 4);
    localparam logic [7:0] A_CONTROL_THREE   = 8'(IDX_CONTROL_THREE * 4);
    localparam logic [7:0] A_STATUS_ONE      = 8'(IDX_STATUS_ONE * 4);
    localparam logic [7:0] A_STATUS_TWO      = 8'(IDX_STATUS_TWO * 4);
    localparam logic [7:0] A_TX_RX_BUFFER    = 8'(IDX_TX_RX_BUFFER * 4);
    localparam logic [7:0] A_BIT_RATE        = 8'(IDX_BIT_RATE * 4);
    // control_one fields
    localparam int C1_MODULE_ENABLE = 6;
    localparam int C1_TX_INVERT     = 5;
    localparam int C1_CHAR9         = 4;
    // control_two fields
    localparam int C2_EMPTY_IE      = 7;
    localparam int C2_DONE_IE       = 6;
    localparam int C2_RX_IE         = 5;
    localparam int C2_TX_ENABLE     = 3;
    localparam int C2_RX_ENABLE     = 2;
    localparam int C2_SEND_BREAK    = 0;
    // control_three fields
    localparam int C3_RX_NINTH      = 7;
    localparam int C3_TX_NINTH      = 6;
    localparam int C3_OVERRUN_IE    = 3;
    localparam int C3_FRAMING_IE    = 1;
    localparam logic [7:0] C3_WMASK = 8'h4f;
    localparam logic [7:0] BR_WMASK = 8'h37;
    // status_one and status_two fields
    localparam int S1_EMPTY         = 7;
    localparam int S1_DONE          = 6;
    localparam int S1_RX_FULL       = 5;
    localparam int S1_OVERRUN       = 3;
    localparam int S1_FRAMING       = 1;
    localparam int S2_BREAK         = 1;
    localparam int S2_RX_ACTIVE     = 0;
    // Frame lengths in bits, including start and stop
    localparam logic [3:0] FRAME_LEN8 = 4'ha;
    localparam logic [3:0] FRAME_LEN9 = 4'hb;
    // Ticks per bit and receive sampling point
    localparam logic [3:0] TICK_LAST  = 4'hf;
    localparam logic [3:0] RX_SAMPLE  = 4'h7;
    localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
endpackage

// ==== tb/serial_peer.sv ====
// Remote serial device: frames what it hears on the line and can send frames back.
// Assumes one bit lasts BIT_CLKS rising edges of clk and the line idles high.
`timescale 1ns/1ps
module serial_peer #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic clk,
    input  wire logic line_in,
    input  wire logic inv,
    input  wire logic nine,
    output logic      line_out
);
    logic        lvl;
    logic [10:0] frame;
    int          frames;
    assign lvl = line_in ^ inv;
    initial begin
        frames   = 0;
        frame    = '0;
        line_out = 1'b1;
    end
    // Mid-bit sampling, start through stop; a glitch at a polarity change is dropped
    always begin
        @(negedge lvl);
        repeat (BIT_CLKS / 2) @(posedge clk);
        if (lvl === 1'b0) begin
            frame = '0;
            for (int i = 0; i < (nine ? 11 : 10); i++) begin
                frame[i] = lvl;
                if (i < (nine ? 10 : 9)) repeat (BIT_CLKS) @(posedge clk);
            end
            frames++;
            if (lvl === 1'b0) @(posedge lvl);
        end
    end
    task automatic send_bits(input logic [10:0] bits, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            line_out <= bits[i];
            repeat (BIT_CLKS) @(posedge clk);
        end
        line_out <= 1'b1;
    endtask
endmodule // serial_peer

// ==== tb/tb.sv ====
// Self-checking bench for the serial transmitter over AHB-Lite.
// Assumes bit_rate stays 0, so one bit lasts 16 clocks.
`timescale 1ns/1ps
module tb;
    import serial_tx_pkg::*;
    logic        SYS_CLK, SRST, HSEL, HWRITE, HREADYOUT, HRESP;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0]  HTRANS;
    logic [2:0]  HSIZE;
    logic        TX_PIN_OUT, TX_PIN_OE_N, TX_IRQ, RX_IRQ, RX_PIN_IN;
    logic        txl, inv, nine;
    int          error_cnt, n_tests, n, f0;
    time         t0;
    assign txl = TX_PIN_OE_N ? 1'b1 : TX_PIN_OUT;  // Pull-up once released
    serial_tx u_dut (.SYS_CLK(SYS_CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .TX_PIN_OUT(TX_PIN_OUT), .TX_PIN_OE_N(TX_PIN_OE_N), .RX_PIN_IN(RX_PIN_IN),
        .TX_IRQ(TX_IRQ), .RX_IRQ(RX_IRQ));
    serial_peer #(.BIT_CLKS(16)) u_peer (.clk(SYS_CLK), .line_in(txl), .inv(inv),
        .nine(nine), .line_out(RX_PIN_IN));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("errors=%0d comparisons=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        HSEL   <= 1'b1;
        HTRANS <= HTRANS_NONSEQ_BIT;
        HADDR  <= {24'h0, a};
        HWRITE <= w;
        do begin
            @(posedge SYS_CLK);
        end while (HREADYOUT !== 1'b1);
        HSEL   <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= {24'h0, d};
        do begin
            @(posedge SYS_CLK);
        end while (HREADYOUT !== 1'b1);
        rd = HRDATA;
        check(HRESP, 1'b0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        check(rd, exp);
    endtask
    task automatic put(input logic [7:0] d);
        f0 = u_peer.frames;
        bus(1'b0, A_STATUS_ONE, 8'h00);
        wr(A_TX_RX_BUFFER, d);
    endtask
    task automatic wait_lvl(input logic v);
        n = 0;
        while (txl !== v) begin
            @(posedge SYS_CLK);
            n++;
        end
    endtask
    task automatic wait_frame;
        n = 0;
        while (u_peer.frames == f0) begin
            @(posedge SYS_CLK);
            n++;
        end
        f0 = u_peer.frames;
    endtask
    task automatic t_reset;
        check({TX_PIN_OUT, TX_PIN_OE_N, TX_IRQ, RX_IRQ}, 4'hc);
        rdchk(A_STATUS_ONE, 32'hc0);
        wr(8'hf0, 8'hff);
        rdchk(8'hf0, 32'h0);
        rdchk(A_CONTROL_TWO, 32'h0);
    endtask
    task automatic t_first;
        wr(A_BIT_RATE, 8'h00);
        wr(A_CONTROL_ONE, 8'h40);
        wr(A_CONTROL_TWO, 8'h08);
        check(TX_PIN_OE_N, 1'b0);
        put(8'ha5);
        rdchk(A_STATUS_ONE, 32'h00);
        wait_lvl(1'b0);
        check(n >= 145 && n <= 180, 1'b1);
        rdchk(A_STATUS_ONE, 32'h80);
        wr(A_CONTROL_TWO, 8'h88);
        repeat (2) @(posedge SYS_CLK);
        check(TX_IRQ, 1'b1);
        wr(A_CONTROL_TWO, 8'h08);
        repeat (2) @(posedge SYS_CLK);
        check(TX_IRQ, 1'b0);
        wait_frame;
        check(u_peer.frame, {2'b01, 8'ha5, 1'b0});
        repeat (40) @(posedge SYS_CLK);
        check(txl, 1'b1);
        rdchk(A_STATUS_ONE, 32'hc0);
        wr(A_TX_RX_BUFFER, 8'h3c);
        rdchk(A_STATUS_ONE, 32'h00);
        wait_frame;
        check(u_peer.frame, {2'b01, 8'h3c, 1'b0});
        repeat (40) @(posedge SYS_CLK);
        wr(A_CONTROL_TWO, 8'h48);
        repeat (2) @(posedge SYS_CLK);
        check(TX_IRQ, 1'b1);
        wr(A_CONTROL_TWO, 8'h08);
    endtask
    task automatic t_nine_inv;
        wr(A_CONTROL_ONE, 8'h50);
        wr(A_CONTROL_THREE, 8'h40);
        rdchk(A_CONTROL_THREE, 32'h40);
        nine = 1'b1;
        put(8'h3c);
        wait_frame;
        check(u_peer.frame, {2'b11, 8'h3c, 1'b0});
        repeat (40) @(posedge SYS_CLK);
        nine = 1'b0;
        wr(A_CONTROL_ONE, 8'h60);
        inv = 1'b1;
        @(posedge SYS_CLK);
        check(txl, 1'b0);
        put(8'h96);
        wait_frame;
        check(u_peer.frame, {2'b01, 8'h96, 1'b0});
        repeat (40) @(posedge SYS_CLK);
        wr(A_CONTROL_ONE, 8'h40);
        inv = 1'b0;
    endtask
    task automatic t_break;
        wr(A_CONTROL_TWO, 8'h09);
        wait_lvl(1'b0);
        t0 = $time;
        repeat (400) @(posedge SYS_CLK);
        bus(1'b0, A_STATUS_ONE, 8'h00);
        check(rd[S1_DONE], 1'b0);
        wr(A_CONTROL_TWO, 8'h08);
        wait_lvl(1'b1);
        n = int'(($time - t0) / 100);
        check((n % 160) == 0 && n >= 480, 1'b1);
        repeat (15) @(posedge SYS_CLK);
        check(txl, 1'b1);
    endtask
    task automatic t_queue;
        put(8'h5a);
        wait_lvl(1'b0);
        wr(A_CONTROL_TWO, 8'h00);
        wr(A_CONTROL_TWO, 8'h08);
        put(8'hc3);
        wait_frame;
        check(u_peer.frame, {2'b01, 8'h5a, 1'b0});
        wait_lvl(1'b0);
        check(n >= 160 && n <= 200, 1'b1);
        wait_frame;
        check(u_peer.frame, {2'b01, 8'hc3, 1'b0});
        put(8'h11);
        wait_lvl(1'b0);
        wr(A_CONTROL_TWO, 8'h00);
        wait_frame;
        check(u_peer.frame, {2'b01, 8'h11, 1'b0});
        put(8'h22);
        repeat (400) @(posedge SYS_CLK);
        check({u_peer.frames == f0, txl}, 2'b11);
        wr(A_CONTROL_TWO, 8'h08);
        wait_lvl(1'b0);
        wr(A_CONTROL_ONE, 8'h00);
        repeat (2) @(posedge SYS_CLK);
        check(TX_PIN_OE_N, 1'b1);
    endtask
    task automatic t_rx;
        wr(A_CONTROL_ONE, 8'h40);
        wr(A_CONTROL_TWO, 8'h04);
        u_peer.send_bits({2'b01, 8'h81, 1'b0}, 10);
        repeat (40) @(posedge SYS_CLK);
        bus(1'b0, A_STATUS_ONE, 8'h00);
        check(rd & 32'h2a, 32'h20);
        rdchk(A_TX_RX_BUFFER, 32'h81);
        u_peer.send_bits(11'h000, 10);
        repeat (40) @(posedge SYS_CLK);
        bus(1'b0, A_STATUS_ONE, 8'h00);
        check(rd & 32'h2a, 32'h22);
        rdchk(A_STATUS_TWO, 32'h02);
        bus(1'b0, A_CONTROL_THREE, 8'h00);
        check(rd[C3_RX_NINTH], 1'b0);
        wr(A_CONTROL_THREE, 8'h02);
        repeat (2) @(posedge SYS_CLK);
        check(RX_IRQ, 1'b1);
        rdchk(A_TX_RX_BUFFER, 32'h00);
    endtask
    initial begin
        SYS_CLK = 1'b0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        SRST = 1'b1;
        HSEL = 1'b0;
        HADDR = '0;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HSIZE = 3'h2;
        HWDATA = '0;
        inv = 1'b0;
        nine = 1'b0;
        error_cnt = 0;
        n_tests = 0;
        f0 = 0;
        repeat (10) @(posedge SYS_CLK);
        SRST <= 1'b0;
        @(posedge SYS_CLK);
        t_reset;
        t_first;
        t_nine_inv;
        t_break;
        t_queue;
        t_rx;
        stop_test;
    end
    // Whole run needs about 3.3k cycles
    initial begin
        #3000000;
        error_cnt++;
        stop_test;
    end
endmodule // tb
